// ==== inc/cpt_pkg.sv ====
// cpt_pkg: register map, field positions and mode encodings of one timer channel
// assumes a 16-bit register port and a single 125 MHz timer clock
`default_nettype none
package cpt_pkg;
	// ----------------------------------------------------------------
	// register indices (one per address)
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_MODE = 5'h00;
	localparam logic [4:0] ADDR_CLOCK = 5'h01;
	localparam logic [4:0] ADDR_TRIG0 = 5'h02;
	localparam logic [4:0] ADDR_TRIG1 = 5'h03;
	localparam logic [4:0] ADDR_PERIOD = 5'h04;
	localparam logic [4:0] ADDR_CH0_RISE = 5'h05;
	localparam logic [4:0] ADDR_CH0_FALL = 5'h06;
	localparam logic [4:0] ADDR_CH1_RISE = 5'h07;
	localparam logic [4:0] ADDR_CH1_FALL = 5'h08;
	localparam logic [4:0] ADDR_COUNTER = 5'h09;
	localparam logic [4:0] ADDR_STATUS = 5'h0a;
	localparam logic [4:0] ADDR_START = 5'h0b;
	localparam logic [4:0] ADDR_STOP = 5'h0c;
	localparam logic [4:0] ADDR_UPDATE = 5'h0d;
	localparam logic [4:0] ADDR_CONTROL = 5'h0e;
	localparam logic [4:0] ADDR_AND_CFG = 5'h0f;
	localparam logic [4:0] ADDR_AND_EN = 5'h10;
	localparam logic [4:0] ADDR_DELAY = 5'h11;
	// ----------------------------------------------------------------
	// mode register fields
	// ----------------------------------------------------------------
	localparam int MODE_CAPTURE_BIT = 0;
	localparam int MODE_ONE_SHOT_BIT = 1;
	localparam int MODE_STOP_SYNC_BIT = 2;
	localparam int MODE_OSEL0_BIT = 3;
	localparam int MODE_OSEL1_BIT = 4;
	localparam int MODE_INV_A_BIT = 5;
	localparam int MODE_INV_B_BIT = 6;
	// ----------------------------------------------------------------
	// common register fields
	// ----------------------------------------------------------------
	localparam int START_BIT = 0;
	localparam int TRIG_EN_BIT = 1;
	localparam int STOP_BIT = 0;
	localparam int UPDATE_BIT = 0;
	localparam int FORCED_LOW_BIT = 0;
	localparam int AND_EN_LO_BIT = 0;
	localparam int AND_EN_HI_BIT = 1;
	// trigger cfg: [3:0] source, [4] start, [5] stop, [6] clear, [7] capture,
	// [9:8] edge (00 rise, 01 fall, 10 both)
	localparam int TRG_SRC_LSB = 0;
	localparam int TRG_START_BIT = 4;
	localparam int TRG_STOP_BIT = 5;
	localparam int TRG_CLEAR_BIT = 6;
	localparam int TRG_CAPTURE_BIT = 7;
	localparam int TRG_EDGE_LSB = 8;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	// ----------------------------------------------------------------
	// reset values and timing
	// ----------------------------------------------------------------
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [15:0] REG_ZERO = 16'h0000;
	localparam int START_SYNC_MAX_CYCLES = 4;
	localparam logic [1:0] START_SYNC_DEPTH = 2'h2;

	typedef struct packed {
		logic [15:0] period;
		logic [15:0] r0;
		logic [15:0] f0;
		logic [15:0] r1;
		logic [15:0] f1;
	} cpt_buf_s;
endpackage : cpt_pkg
`default_nettype wire

// ==== rtl/cpt_timer.sv ====
// cpt_timer: one 16-bit capture/pwm timer channel with register port
// assumes trigger and comparator inputs come from outside the clock domain
`default_nettype none
module cpt_timer
	import cpt_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int CLK_DIV_BITS = 8
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET_N,
	// register port
	input wire logic [4:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	// trigger and output gate sources
	input wire logic [3:0] EXT_TRIG,
	input wire logic HOLD_TIMER_INT,
	input wire logic WATCHDOG_CLK,
	input wire logic CHANNEL_TRIG,
	input wire logic [1:0] COMP_INT,
	input wire logic [7:0] AND_SRC,
	// pins
	output logic OUTPUT_PIN_A,
	output logic OUTPUT_PIN_B,
	output logic RUNNING
);
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN} cpt_state_e;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [15:0] mode_q, clock_q, trig0_q, trig1_q, delay_q, and_cfg_q;
	logic [1:0] and_en_q;
	logic forced_low_q, trig_en_q;
	cpt_buf_s shadow_q, active_q;
	logic [WIDTH-1:0] count_q;
	logic [15:0] rdata_q;
	cpt_state_e state_q;
	logic [1:0] start_sync_q;
	logic upd_pend_q;
	logic [CLK_DIV_BITS-1:0] div_q;
	logic [10:0] trg_meta_q, trg_sync_q, trg_prev_q;
	logic wave0_q, wave1_q, pin_a_q, pin_b_q;

	wire wr_mode = WR && ADDR == ADDR_MODE;
	wire wr_count = WR && ADDR == ADDR_COUNTER;
	wire wr_start = WR && ADDR == ADDR_START;
	wire wr_stop = WR && ADDR == ADDR_STOP;
	wire wr_update = WR && ADDR == ADDR_UPDATE;
	wire running = state_q != ST_IDLE;

	// ----------------------------------------------------------------
	// count clock enable from divider
	// ----------------------------------------------------------------
	// clock select low bits divide the timer clock by their value plus one
	wire tick = (div_q >= clock_q[CLK_DIV_BITS-1:0]);

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			div_q <= '0;
		end else begin
			div_q <= tick ? '0 : div_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// trigger source synchronise and select
	// ----------------------------------------------------------------
	// source index: 0-3 external, 4 hold timer, 5 watchdog clock, 6-7 own waveforms,
	// 8 channel trigger, 9-10 comparators
	wire [10:0] trg_raw = {COMP_INT, CHANNEL_TRIG, wave1_q, wave0_q, WATCHDOG_CLK,
		HOLD_TIMER_INT, EXT_TRIG};

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			trg_meta_q <= '0;
			trg_sync_q <= '0;
			trg_prev_q <= '0;
		end else begin
			trg_meta_q <= trg_raw;
			trg_sync_q <= trg_meta_q;
			trg_prev_q <= trg_sync_q;
		end
	end

	function automatic logic [1:0] edges(input logic [15:0] cfg, input logic [10:0] cur,
		input logic [10:0] prv);
		logic [3:0] sel;
		logic r, f;
		sel = cfg[TRG_SRC_LSB +: 4];
		r = (sel < 4'hb) ? (cur[sel] & ~prv[sel]) : 1'b0;
		f = (sel < 4'hb) ? (~cur[sel] & prv[sel]) : 1'b0;
		edges = {f, r};
	endfunction

	function automatic logic fire(input logic [15:0] cfg, input logic [1:0] e);
		logic [1:0] m;
		m = cfg[TRG_EDGE_LSB +: 2];
		fire = (m == EDGE_RISE) ? e[0] : (m == EDGE_FALL) ? e[1] : (e[0] | e[1]);
	endfunction

	wire [1:0] e0 = edges(trig0_q, trg_sync_q, trg_prev_q);
	wire [1:0] e1 = edges(trig1_q, trg_sync_q, trg_prev_q);
	wire f0 = trig_en_q && fire(trig0_q, e0);
	wire f1 = trig_en_q && fire(trig1_q, e1);
	wire t_start = (f0 && trig0_q[TRG_START_BIT]) || (f1 && trig1_q[TRG_START_BIT]);
	wire t_stop = (f0 && trig0_q[TRG_STOP_BIT]) || (f1 && trig1_q[TRG_STOP_BIT]);
	wire t_clear = (f0 && trig0_q[TRG_CLEAR_BIT]) || (f1 && trig1_q[TRG_CLEAR_BIT]);
	wire cap_rise = trig_en_q && mode_q[MODE_CAPTURE_BIT] && (trig0_q[TRG_CAPTURE_BIT] ?
		e0[0] : (trig1_q[TRG_CAPTURE_BIT] && e1[0]));
	wire cap_fall = trig_en_q && mode_q[MODE_CAPTURE_BIT] && (trig0_q[TRG_CAPTURE_BIT] ?
		e0[1] : (trig1_q[TRG_CAPTURE_BIT] && e1[1]));

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	wire sw_start = wr_start && WDATA[START_BIT];
	wire sw_stop = wr_stop && WDATA[STOP_BIT] && running;
	wire start_go = start_sync_q[1] || t_start;
	wire stop_req = sw_stop || (t_stop && running);
	wire overflow = tick && running && count_q >= active_q.period;
	wire drain_done = tick && count_q >= delay_q;

	// two-stage start pipe keeps the run status within four cycles of the write
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			start_sync_q <= '0;
		end else begin
			start_sync_q <= {start_sync_q[0], sw_start};
		end
	end

	cpt_state_e state_d;
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start_go) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (stop_req && mode_q[MODE_STOP_SYNC_BIT]) begin
					state_d = ST_DRAIN;
				end else if (stop_req) begin
					state_d = ST_IDLE;
				end else if (overflow && mode_q[MODE_ONE_SHOT_BIT]) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				if (overflow) begin
					state_d = ST_DRAIN;
				end
				if (!overflow && drain_done && count_q < active_q.period) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// drain waits for the period end before counting up to the delay value
	logic drain_wrap_q;
	// the drain ends on the first tick with the count at the delay value, which is then held
	wire drain_stop = state_q == ST_DRAIN && drain_wrap_q && drain_done;
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_q <= ST_IDLE;
			drain_wrap_q <= 1'b0;
		end else begin
			drain_wrap_q <= (state_q == ST_DRAIN) ? (drain_wrap_q | overflow) : 1'b0;
			if (state_q == ST_DRAIN && !(drain_wrap_q && drain_done)) begin
				state_q <= ST_DRAIN;
			end else if (state_q == ST_DRAIN) begin
				state_q <= ST_IDLE;
			end else begin
				state_q <= state_d;
			end
		end
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	// a write or a trigger clear wins over counting; the last drain count is kept
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			count_q <= '0;
		end else if (wr_count || t_clear) begin
			count_q <= '0;
		end else if (overflow) begin
			count_q <= '0;
		end else if (tick && running && !drain_stop) begin
			count_q <= count_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// buffer update
	// ----------------------------------------------------------------
	// a pending update set wins over its clear, so no request is lost
	wire idle_start = state_q == ST_IDLE && start_go;
	wire load_now = idle_start || wr_count || (upd_pend_q && !running);
	wire load_cycle = upd_pend_q && overflow;

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			upd_pend_q <= 1'b0;
			active_q <= '{PERIOD_RESET, REG_ZERO, REG_ZERO, REG_ZERO, REG_ZERO};
		end else begin
			if (wr_update && WDATA[UPDATE_BIT]) begin
				upd_pend_q <= 1'b1;
			end else if (load_now || load_cycle) begin
				upd_pend_q <= 1'b0;
			end
			if (load_now || load_cycle) begin
				active_q <= shadow_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// register writes and capture
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mode_q <= '0;
			clock_q <= '0;
			trig0_q <= '0;
			trig1_q <= '0;
			delay_q <= '0;
			and_cfg_q <= '0;
			and_en_q <= '0;
			forced_low_q <= 1'b0;
			trig_en_q <= 1'b0;
			shadow_q <= '{PERIOD_RESET, REG_ZERO, REG_ZERO, REG_ZERO, REG_ZERO};
		end else begin
			if (wr_mode) mode_q <= WDATA;
			if (WR && ADDR == ADDR_CLOCK) clock_q <= WDATA;
			if (WR && ADDR == ADDR_TRIG0) trig0_q <= WDATA;
			if (WR && ADDR == ADDR_TRIG1) trig1_q <= WDATA;
			if (WR && ADDR == ADDR_DELAY) delay_q <= WDATA;
			if (WR && ADDR == ADDR_AND_CFG) and_cfg_q <= WDATA;
			if (WR && ADDR == ADDR_AND_EN) and_en_q <= WDATA[1:0];
			if (WR && ADDR == ADDR_CONTROL) forced_low_q <= WDATA[FORCED_LOW_BIT];
			if (wr_start) trig_en_q <= WDATA[TRIG_EN_BIT];
			if (WR && ADDR == ADDR_PERIOD && WDATA != REG_ZERO) shadow_q.period <= WDATA;
			if (WR && ADDR == ADDR_CH0_RISE) shadow_q.r0 <= WDATA;
			if (WR && ADDR == ADDR_CH0_FALL) shadow_q.f0 <= WDATA;
			if (WR && ADDR == ADDR_CH1_RISE) shadow_q.r1 <= WDATA;
			if (WR && ADDR == ADDR_CH1_FALL) shadow_q.f1 <= WDATA;
			if (cap_rise) shadow_q.r0 <= count_q;
			if (cap_fall) shadow_q.f0 <= count_q;
		end
	end

	// ----------------------------------------------------------------
	// output gate sources synchronise
	// ----------------------------------------------------------------
	// gate sources come from pins and comparators outside this clock
	logic [7:0] and_meta_q, and_sync_q;

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			and_meta_q <= '0;
			and_sync_q <= '0;
		end else begin
			and_meta_q <= AND_SRC;
			and_sync_q <= and_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// waveform and pins
	// ----------------------------------------------------------------
	wire pwm = running && !mode_q[MODE_CAPTURE_BIT];
	wire [3:0] and_lo = and_en_q[0] ? and_cfg_q[3:0] : 4'h0;
	wire [3:0] and_hi = and_en_q[1] ? and_cfg_q[11:8] : 4'h0;
	wire gate_a = &(~and_lo | and_sync_q[3:0]);
	wire gate_b = &(~and_hi | and_sync_q[7:4]);
	wire sel_a = mode_q[MODE_OSEL0_BIT] ? wave1_q : wave0_q;
	wire sel_b = mode_q[MODE_OSEL1_BIT] ? wave0_q : wave1_q;

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wave0_q <= 1'b0;
			wave1_q <= 1'b0;
			pin_a_q <= 1'b0;
			pin_b_q <= 1'b0;
		end else begin
			// forced low and stop both park the waveforms ahead of the pin select
			if (forced_low_q || !pwm) begin
				wave0_q <= 1'b0;
				wave1_q <= 1'b0;
			end else if (tick) begin
				if (count_q == active_q.r0) wave0_q <= 1'b1;
				else if (count_q == active_q.f0) wave0_q <= 1'b0;
				if (count_q == active_q.r1) wave1_q <= 1'b1;
				else if (count_q == active_q.f1) wave1_q <= 1'b0;
			end
			pin_a_q <= (sel_a & gate_a) ^ mode_q[MODE_INV_A_BIT];
			pin_b_q <= (sel_b & gate_b) ^ mode_q[MODE_INV_B_BIT];
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// read data stand for the one cycle after the strobe, zero otherwise
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = REG_ZERO;
		if (ADDR == ADDR_MODE) rd_mux = mode_q;
		else if (ADDR == ADDR_CLOCK) rd_mux = clock_q;
		else if (ADDR == ADDR_TRIG0) rd_mux = trig0_q;
		else if (ADDR == ADDR_TRIG1) rd_mux = trig1_q;
		else if (ADDR == ADDR_PERIOD) rd_mux = shadow_q.period;
		else if (ADDR == ADDR_CH0_RISE) rd_mux = shadow_q.r0;
		else if (ADDR == ADDR_CH0_FALL) rd_mux = shadow_q.f0;
		else if (ADDR == ADDR_CH1_RISE) rd_mux = shadow_q.r1;
		else if (ADDR == ADDR_CH1_FALL) rd_mux = shadow_q.f1;
		else if (ADDR == ADDR_COUNTER) rd_mux = count_q;
		else if (ADDR == ADDR_STATUS) rd_mux = {13'h0000, upd_pend_q, pin_b_q, running};
		else if (ADDR == ADDR_START) rd_mux = {14'h0000, trig_en_q, 1'b0};
		else if (ADDR == ADDR_CONTROL) rd_mux = {15'h0000, forced_low_q};
		else if (ADDR == ADDR_AND_CFG) rd_mux = and_cfg_q;
		else if (ADDR == ADDR_AND_EN) rd_mux = {14'h0000, and_en_q};
		else if (ADDR == ADDR_DELAY) rd_mux = delay_q;
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_q <= '0;
			RUNNING <= 1'b0;
		end else begin
			rdata_q <= RD ? rd_mux : REG_ZERO;
			RUNNING <= running;
		end
	end

	assign RDATA = rdata_q;
	assign OUTPUT_PIN_A = pin_a_q;
	assign OUTPUT_PIN_B = pin_b_q;
endmodule // cpt_timer
`default_nettype wire

// ==== tb/cpt_timer_assertions.sv ====
// cpt_timer_assertions: port-level checks of one timer channel
// assumes it is bound to cpt_timer and sees that module's ports only
`default_nettype none
module cpt_timer_assertions
	import cpt_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RESET_N,
	// register port
	input wire logic [4:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	// pins and status
	input wire logic OUTPUT_PIN_A,
	input wire logic OUTPUT_PIN_B,
	input wire logic RUNNING
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	// ----------------------------------------------------------------
	// shadow of the settings the checks depend on
	// ----------------------------------------------------------------
	logic sync_q;
	logic forced_q;
	logic inv_a_q;
	logic inv_b_q;
	logic [15:0] period_q;
	logic [2:0] low_cnt_q;
	wire logic mode_wr = WR && ADDR == ADDR_MODE;
	wire logic ctrl_wr = WR && ADDR == ADDR_CONTROL;
	wire logic low_hold = forced_q && !mode_wr && !ctrl_wr;
	wire logic [2:0] low_cnt_d = !low_hold ? 3'h0 : low_cnt_q + {2'h0, low_cnt_q != 3'h7};
	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sync_q <= 1'b0;
			forced_q <= 1'b0;
			inv_a_q <= 1'b0;
			inv_b_q <= 1'b0;
			period_q <= PERIOD_RESET;
			low_cnt_q <= 3'h0;
		end else begin
			if (mode_wr) sync_q <= WDATA[MODE_STOP_SYNC_BIT];
			if (mode_wr) inv_a_q <= WDATA[MODE_INV_A_BIT];
			if (mode_wr) inv_b_q <= WDATA[MODE_INV_B_BIT];
			if (ctrl_wr) forced_q <= WDATA[FORCED_LOW_BIT];
			if (WR && ADDR == ADDR_PERIOD && WDATA != REG_ZERO) period_q <= WDATA;
			low_cnt_q <= low_cnt_d;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_start_runs: assert property (WR && ADDR == ADDR_START && WDATA[START_BIT] && !RUNNING
		|-> ##[1:4] RUNNING) else $error("run status late after start");
	a_stop_halts: assert property (WR && ADDR == ADDR_STOP && WDATA[STOP_BIT] && RUNNING
		&& !sync_q |-> ##[1:5] !RUNNING) else $error("run status still set after stop");
	a_status_match: assert property (RD && ADDR == ADDR_STATUS |=> RDATA[0] == RUNNING)
		else $error("status read disagrees with run pin");
	a_counter_clear: assert property ((WR && ADDR == ADDR_COUNTER && !RUNNING) ##2
		(RD && ADDR == ADDR_COUNTER) |=> RDATA == REG_ZERO) else $error("counter not cleared");
	a_period_range: assert property (RD && ADDR == ADDR_PERIOD |=> RDATA == period_q)
		else $error("period read back wrong");
	a_forced_low_a: assert property (low_cnt_q == 3'h7 |-> OUTPUT_PIN_A == inv_a_q)
		else $error("pin a not at its parked level when forced");
	a_forced_low_b: assert property (low_cnt_q == 3'h7 |-> OUTPUT_PIN_B == inv_b_q)
		else $error("pin b not at its parked level when forced");
	a_unmapped_zero: assert property (RD && ADDR > ADDR_DELAY |=> RDATA == REG_ZERO)
		else $error("unmapped read not zero");
endmodule // cpt_timer_assertions

bind cpt_timer cpt_timer_assertions u_cpt_timer_assertions (
	.REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .OUTPUT_PIN_A(OUTPUT_PIN_A), .OUTPUT_PIN_B(OUTPUT_PIN_B), .RUNNING(RUNNING)
);
`default_nettype wire

// ==== tb/cpt_timer_tb.sv ====
// cpt_timer_tb: register-level tests of one timer channel
// assumes cpt_pkg, the design and the bound checker are compiled first
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module cpt_timer_tb
	import cpt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk;
	logic reset_n = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] ext_trig = 4'h0;
	logic [7:0] and_src = 8'h00;
	wire logic [15:0] rdata;
	wire logic pin_a;
	wire logic pin_b;
	wire logic running;
	int miscompares = 0;
	int n_tests = 0;
	logic [15:0] v1;
	logic [15:0] v2;
	cpt_timer u_cpt_timer (
		.REF_CLK(ref_clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .EXT_TRIG(ext_trig), .HOLD_TIMER_INT(1'b0), .WATCHDOG_CLK(1'b0),
		.CHANNEL_TRIG(1'b0), .COMP_INT(2'h0), .AND_SRC(and_src), .OUTPUT_PIN_A(pin_a),
		.OUTPUT_PIN_B(pin_b), .RUNNING(running)
	);
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// ----------------------------------------------------------------
	// register access
	// ----------------------------------------------------------------
	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic wait_run(input logic lvl);
		int i;
		i = 0;
		#1;
		while (i < 64 && running !== lvl) begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		`CHK("running", lvl, running)
	endtask
	task automatic run_stop(input int n);
		reg_wr(ADDR_START, 16'h0001);
		wait_run(1'b1);
		repeat (n) @(posedge ref_clk);
		reg_wr(ADDR_STOP, 16'h0001);
		wait_run(1'b0);
		reg_rd(ADDR_COUNTER, v1);
	endtask
	task automatic print_verdict;
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		reg_rd(ADDR_PERIOD, v1);
		`CHK("period reset", PERIOD_RESET, v1)
		reg_rd(5'h1f, v1);
		`CHK("unmapped", REG_ZERO, v1)
		reg_wr(ADDR_CLOCK, 16'h0000);
		reg_wr(ADDR_PERIOD, 16'h0000);
		reg_rd(ADDR_PERIOD, v1);
		`CHK("period zero", PERIOD_RESET, v1)
		reg_wr(ADDR_START, 16'h0001);
		wait_run(1'b1);
		reg_rd(ADDR_STATUS, v1);
		`CHK("status run", 1'b1, v1[0])
		repeat (20) @(posedge ref_clk);
		reg_wr(ADDR_STOP, 16'h0001);
		wait_run(1'b0);
		reg_rd(ADDR_COUNTER, v1);
		repeat (5) @(posedge ref_clk);
		reg_rd(ADDR_COUNTER, v2);
		`CHK("held", v1, v2)
		`CHK("counted", 1'b1, v1 > 16'h0010)
		run_stop(0);
		`CHK("resumed", 1'b1, v1 > v2)
		reg_wr(ADDR_COUNTER, 16'h1234);
		reg_rd(ADDR_COUNTER, v1);
		`CHK("cleared", REG_ZERO, v1)
		reg_wr(ADDR_PERIOD, 16'h0009);
		reg_wr(ADDR_START, 16'h0001);
		wait_run(1'b1);
		repeat (40) @(posedge ref_clk);
		reg_wr(ADDR_PERIOD, 16'hffff);
		repeat (30) @(posedge ref_clk);
		#1;
		`CHK("continuous", 1'b1, running)
		reg_wr(ADDR_STOP, 16'h0001);
		wait_run(1'b0);
		reg_rd(ADDR_COUNTER, v1);
		`CHK("wrapped", 1'b1, v1 <= 16'h0009)
		reg_wr(ADDR_UPDATE, 16'h0001);
		run_stop(40);
		`CHK("update applied", 1'b1, v1 > 16'h0009)
		reg_wr(ADDR_COUNTER, 16'h0000);
		reg_rd(ADDR_COUNTER, v1);
		`CHK("zero before start", REG_ZERO, v1)
		reg_wr(ADDR_PERIOD, 16'h0009);
		reg_wr(ADDR_MODE, 16'h0002);
		reg_wr(ADDR_START, 16'h0001);
		wait_run(1'b1);
		wait_run(1'b0);
		reg_rd(ADDR_COUNTER, v1);
		`CHK("one shot end", REG_ZERO, v1)
		reg_wr(ADDR_MODE, 16'h0004);
		reg_wr(ADDR_DELAY, 16'h0003);
		run_stop(0);
		`CHK("stop delay", 16'h0003, v1)
		reg_wr(ADDR_MODE, 16'h0000);
		reg_wr(ADDR_START, 16'h0001);
		reg_wr(ADDR_CONTROL, 16'h0001);
		repeat (8) @(posedge ref_clk);
		#1;
		`CHK("forced a", 1'b0, pin_a)
		`CHK("forced b", 1'b0, pin_b)
		and_src <= 8'hff;
		reg_wr(ADDR_AND_CFG, 16'h0f0f);
		reg_wr(ADDR_AND_EN, 16'h0003);
		reg_wr(ADDR_MODE, 16'h0060);
		repeat (8) @(posedge ref_clk);
		#1;
		`CHK("inverted a", 1'b1, pin_a)
		`CHK("inverted b", 1'b1, pin_b)
		reg_wr(ADDR_CONTROL, 16'h0000);
		reg_wr(ADDR_MODE, 16'h0000);
		repeat (16) @(posedge ref_clk);
		#1;
		`CHK("passed a", 1'b1, pin_a)
		@(posedge ref_clk);
		and_src <= 8'hf0;
		repeat (8) @(posedge ref_clk);
		#1;
		`CHK("gated a", 1'b0, pin_a)
		`CHK("open b", 1'b1, pin_b)
		reg_wr(ADDR_STOP, 16'h0001);
		wait_run(1'b0);
		reg_wr(ADDR_COUNTER, 16'h0000);
		reg_wr(ADDR_PERIOD, 16'hffff);
		reg_wr(ADDR_MODE, 16'h0001);
		reg_wr(ADDR_TRIG0, 16'h0090);
		reg_wr(ADDR_START, 16'h0002);
		ext_trig <= 4'h1;
		wait_run(1'b1);
		repeat (20) @(posedge ref_clk);
		ext_trig <= 4'h0;
		repeat (20) @(posedge ref_clk);
		ext_trig <= 4'h1;
		repeat (10) @(posedge ref_clk);
		reg_rd(ADDR_CH0_FALL, v1);
		reg_rd(ADDR_CH0_RISE, v2);
		`CHK("capture fall", 1'b1, v1 > 16'h000a)
		`CHK("capture rise", 1'b1, v2 > v1)
		print_verdict();
	end
	initial begin
		#32000;
		miscompares++;
		print_verdict();
	end
endmodule // cpt_timer_tb
`undef CHK
`default_nettype wire
